//--- shared/rsb_cfg.svh
// Offsets, bit positions, reset values and counts for the reset sequencer
`ifndef RSB_CFG_SVH
`define RSB_CFG_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define RSB_IDX_CHIP     8'h9f
`define RSB_IDX_FLAGS    8'ha2
`define RSB_IDX_WDOG     8'haa
`define RSB_IDX_FAULT    8'hb0
`define RSB_AW           10
`define RSB_DW           8

// ==========================================================
// chip_control fields
`define RSB_CHIP_SWREQ   7
`define RSB_CHIP_PFAIL   6
`define RSB_CHIP_BOOT    1
`define RSB_CHIP_PEN     0

// ==========================================================
// reset_flags_aux fields
`define RSB_FLG_SOFT     7
`define RSB_FLG_PIN      6
`define RSB_FLG_FAULT    5
`define RSB_FLG_IRQSEL   4
`define RSB_FLG_GEN      3
`define RSB_FLG_DPTR     0
`define RSB_FLG_POR      8'h00

// ==========================================================
// watchdog_control fields
`define RSB_WD_RUN       7
`define RSB_WD_CLR       6
`define RSB_WD_TOF       5
`define RSB_WD_IDLE      4
`define RSB_WD_RSTF      3
`define RSB_WD_PS_HI     2
`define RSB_WD_PS_LO     0
`define RSB_WD_POR       8'h07

// ==========================================================
// fault_control and configuration byte fields
`define RSB_FC_IRQ_EN    0
`define RSB_CFG_BOOT     7
`define RSB_CFG_DBG      4

// ==========================================================
// Addresses and counts
`define RSB_FLASH_LIMIT  16'h2000
`define RSB_RESET_VECTOR 16'h0000
`define RSB_PIN_LOW_CNT  5'h18
`define RSB_HOLD_CNT     5'h08
`define RSB_CNT_ONE      5'h01
`define RSB_CNT_ZERO     5'h00

`endif

//--- shared/rsb_pkg.sv
// Types shared by the reset sequencer modules
package rsb_pkg;

   // ==========================================================
   // Sequencer states, one-hot
   typedef enum logic [1:0] {
      RSB_RUN  = 2'b01,
      RSB_HOLD = 2'b10
   } rsb_state_t;

   // ==========================================================
   // Cause of the reset in progress, one-hot
   typedef enum logic [4:0] {
      RSB_K_NONE  = 5'b00001,
      RSB_K_SOFT  = 5'b00010,
      RSB_K_PIN   = 5'b00100,
      RSB_K_WDOG  = 5'b01000,
      RSB_K_FAULT = 5'b10000
   } rsb_kind_t;

endpackage

//--- shared/rsb_pin_if.sv
// Carrier between the reset pin filter and the sequencer
`timescale 1ns/1ps
interface rsb_pin_if;
   logic pin_reset;   // Pin held low long enough, level

   // ==========================================================
   // Filter drives, sequencer listens
   modport filter (output pin_reset);
   modport seq    (input  pin_reset);
endinterface

//--- design/rsb_pin_filter.sv
// Reset pin synchroniser and low-time qualifier
`timescale 1ns/1ps
`include "rsb_cfg.svh"
module rsb_pin_filter (
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   input  wire logic  reset_pin_n_i,
   rsb_pin_if.filter  pin
);
   logic [2:0] sync;
   logic       pin_low;
   logic [4:0] low_cnt;

   // ==========================================================
   // Three stages; a change counts once stages two and three agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync <= 3'h7;
      end else begin
         sync <= {sync[1:0], reset_pin_n_i};
      end
   end

   // Stable level, only updated when the last two stages agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_low <= 1'b0;
      end else if (sync[1] == sync[2]) begin
         pin_low <= ~sync[2];
      end
   end

   // ==========================================================
   // Low must last the full count; short glitches are ignored
   always_ff @(posedge clk_i) begin
      if (rst_i || !pin_low) begin
         low_cnt <= `RSB_CNT_ZERO;
      end else if (low_cnt != `RSB_PIN_LOW_CNT) begin
         low_cnt <= low_cnt + `RSB_CNT_ONE;
      end
   end

   // Held until the pin goes high again
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin.pin_reset <= 1'b0;
      end else begin
         pin.pin_reset <= pin_low && (low_cnt == `RSB_PIN_LOW_CNT);
      end
   end
endmodule

//--- design/rsb_top.sv
// Reset source flags, software reset and boot area selection
//
// Summary of operation
// - A qualified reset pin event resets the system and sets the pin flag.
// - Fetch beyond flash with fault interrupt off resets and sets fault flag.
// - In debug with debugger config bit 0, a bad fetch only sets the flag.
// - Watchdog expiry resets the whole system; CPU restarts at 0000H.
// - Watchdog flag set by watchdog reset, kept by others, software clears.
// - Software watchdog clear restarts the watchdog count at any moment.
// - Watchdog control is timed-access, 07h on power-on, 0000_1UUU on wdog.
// - Writing 1 to soft reset request under timed access starts soft reset.
// - The CPU is held from the requesting write on; nothing else executes.
// - Hardware clears the soft reset request when the reset is finished.
// - Soft reset flag set by soft reset, kept by others, software clears.
// - Flags: power-on 00h, soft 1U00_0000, pin U100_0000, watchdog UUU0_0000, fault as watchdog with bit 5 set.
// - After reset fetch starts at 0000H of application or loader area.
// - Boot select reloads inverted config boot bit except on soft reset.
// - Leaving reset uses the live boot select, not the config bit.
`timescale 1ns/1ps
`include "rsb_cfg.svh"
module rsb_top (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [`RSB_AW-1:0]   wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   input  wire logic                 reset_pin_n_i,
   input  wire logic                 ta_open_i,
   input  wire logic [`RSB_DW-1:0]   config_byte_zero_i,
   input  wire logic                 ocd_active_i,
   input  wire logic                 fetch_valid_i,
   input  wire logic [15:0]          fetch_addr_i,
   input  wire logic                 wdt_expired_i,
   output logic                      sys_rst_o,
   output logic                      cpu_hold_o,
   output logic                      boot_loader_o,
   output logic      [15:0]          restart_addr_o,
   output logic                      watchdog_clear_o,
   output logic                      watchdog_run_o,
   output logic      [2:0]           watchdog_prescale_o
);

   // ==========================================================
   // Declarations
   rsb_pin_if            pin_bus ();
   rsb_pkg::rsb_state_t  state;
   rsb_pkg::rsb_kind_t   kind;
   rsb_pkg::rsb_kind_t   next_kind;
   logic [4:0]           hold_cnt;
   logic [`RSB_DW-1:0]   chip_control;
   logic [`RSB_DW-1:0]   reset_flags_aux;
   logic [`RSB_DW-1:0]   watchdog_control;
   logic [`RSB_DW-1:0]   fault_control;
   logic [`RSB_DW-1:0]   next_rdata;
   logic [`RSB_DW-1:0]   wdata;
   logic                 req;
   logic                 wr;
   logic                 sel_chip;
   logic                 sel_flags;
   logic                 sel_wdog;
   logic                 sel_fault;
   logic                 wr_chip;
   logic                 wr_flags;
   logic                 wr_wdog;
   logic                 wr_fault;
   logic                 soft_wr;
   logic                 fault_hit;
   logic                 fault_quiet;
   logic                 fault_reset;
   logic                 enter;
   logic                 leave;
   logic                 boot_reload;

   // ==========================================================
   // Pin qualifier
   rsb_pin_filter u_pin (
      .clk_i         (clk_i),
      .rst_i         (rst_i),
      .reset_pin_n_i (reset_pin_n_i),
      .pin           (pin_bus.filter)
   );

   // ==========================================================
   // Bus decode; one request per ack, ack lasts one cycle
   assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr        = req && wb_we_i && wb_sel_i[0];
   assign wdata     = wb_dat_i[`RSB_DW-1:0];
   assign sel_chip  = wb_adr_i[`RSB_AW-1:2] == `RSB_IDX_CHIP;
   assign sel_flags = wb_adr_i[`RSB_AW-1:2] == `RSB_IDX_FLAGS;
   assign sel_wdog  = wb_adr_i[`RSB_AW-1:2] == `RSB_IDX_WDOG;
   assign sel_fault = wb_adr_i[`RSB_AW-1:2] == `RSB_IDX_FAULT;

   // Protected registers ignore writes outside the access window
   assign wr_chip   = wr && sel_chip && ta_open_i;
   assign wr_wdog   = wr && sel_wdog && ta_open_i;
   assign wr_flags  = wr && sel_flags;
   assign wr_fault  = wr && sel_fault;
   assign soft_wr   = wr_chip && wdata[`RSB_CHIP_SWREQ];

   // ==========================================================
   // Fetch fault detection
   assign fault_hit   = fetch_valid_i && (state == rsb_pkg::RSB_RUN)
                        && (fetch_addr_i >= `RSB_FLASH_LIMIT);
   assign fault_quiet = ocd_active_i
                        && !config_byte_zero_i[`RSB_CFG_DBG];
   assign fault_reset = fault_hit && !fault_quiet
                        && !fault_control[`RSB_FC_IRQ_EN];

   // ==========================================================
   // Reset cause priority: pin, watchdog, fault, software
   always_comb begin
      next_kind = rsb_pkg::RSB_K_NONE;
      if (state == rsb_pkg::RSB_RUN) begin
         if (pin_bus.pin_reset) begin
            next_kind = rsb_pkg::RSB_K_PIN;
         end else if (wdt_expired_i) begin
            next_kind = rsb_pkg::RSB_K_WDOG;
         end else if (fault_reset) begin
            next_kind = rsb_pkg::RSB_K_FAULT;
         end else if (chip_control[`RSB_CHIP_SWREQ]) begin
            next_kind = rsb_pkg::RSB_K_SOFT;
         end
      end
   end

   assign enter = next_kind != rsb_pkg::RSB_K_NONE;
   // Pin reset lasts as long as the pin stays low
   assign leave = (state == rsb_pkg::RSB_HOLD)
                  && (hold_cnt == `RSB_HOLD_CNT)
                  && !((kind == rsb_pkg::RSB_K_PIN) && pin_bus.pin_reset);
   assign boot_reload = enter && (next_kind != rsb_pkg::RSB_K_SOFT);

   // ==========================================================
   // Sequencer state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= rsb_pkg::RSB_HOLD;
         kind  <= rsb_pkg::RSB_K_NONE;
      end else begin
         case (state)
            rsb_pkg::RSB_RUN: begin
               if (enter) begin
                  state <= rsb_pkg::RSB_HOLD;
                  kind  <= next_kind;
               end
            end
            rsb_pkg::RSB_HOLD: begin
               if (leave) begin
                  state <= rsb_pkg::RSB_RUN;
                  kind  <= rsb_pkg::RSB_K_NONE;
               end
            end
            default: begin
               state <= rsb_pkg::RSB_HOLD;
               kind  <= rsb_pkg::RSB_K_NONE;
            end
         endcase
      end
   end

   // Minimum reset length counter
   always_ff @(posedge clk_i) begin
      if (rst_i || enter) begin
         hold_cnt <= `RSB_CNT_ZERO;
      end else if ((state == rsb_pkg::RSB_HOLD)
                   && (hold_cnt != `RSB_HOLD_CNT)) begin
         hold_cnt <= hold_cnt + `RSB_CNT_ONE;
      end
   end

   // ==========================================================
   // chip_control: request bit lives until the reset completes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chip_control <= '0;
         chip_control[`RSB_CHIP_BOOT] <=
            ~config_byte_zero_i[`RSB_CFG_BOOT];
      end else if (enter) begin
         chip_control[`RSB_CHIP_PFAIL] <= 1'b0;
         chip_control[`RSB_CHIP_PEN]   <= 1'b0;
         if (boot_reload) begin
            chip_control[`RSB_CHIP_BOOT] <=
               ~config_byte_zero_i[`RSB_CFG_BOOT];
         end
      end else if (leave) begin
         chip_control[`RSB_CHIP_SWREQ] <= 1'b0;
      end else if (wr_chip && (state == rsb_pkg::RSB_RUN)) begin
         chip_control[`RSB_CHIP_SWREQ] <= wdata[`RSB_CHIP_SWREQ];
         chip_control[`RSB_CHIP_PFAIL] <= wdata[`RSB_CHIP_PFAIL];
         chip_control[`RSB_CHIP_BOOT]  <= wdata[`RSB_CHIP_BOOT];
         chip_control[`RSB_CHIP_PEN]   <= wdata[`RSB_CHIP_PEN];
      end
   end

   // ==========================================================
   // reset_flags_aux: hardware sets win over software clears
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reset_flags_aux <= `RSB_FLG_POR;
      end else if (enter) begin
         // Low control bits return to zero on every reset
         reset_flags_aux[`RSB_FLG_IRQSEL:0] <= '0;
         case (next_kind)
            rsb_pkg::RSB_K_SOFT: begin
               reset_flags_aux[`RSB_FLG_SOFT]  <= 1'b1;
               reset_flags_aux[`RSB_FLG_FAULT] <= 1'b0;
            end
            rsb_pkg::RSB_K_PIN: begin
               reset_flags_aux[`RSB_FLG_PIN]   <= 1'b1;
               reset_flags_aux[`RSB_FLG_FAULT] <= 1'b0;
            end
            rsb_pkg::RSB_K_FAULT: begin
               reset_flags_aux[`RSB_FLG_FAULT] <= 1'b1;
            end
            default: begin
               reset_flags_aux[`RSB_FLG_FAULT] <=
                  reset_flags_aux[`RSB_FLG_FAULT];
            end
         endcase
      end else begin
         if (wr_flags) begin
            // Plain write; a 0 clears only its own flag
            reset_flags_aux[`RSB_FLG_SOFT]   <= wdata[`RSB_FLG_SOFT];
            reset_flags_aux[`RSB_FLG_PIN]    <= wdata[`RSB_FLG_PIN];
            reset_flags_aux[`RSB_FLG_FAULT]  <= wdata[`RSB_FLG_FAULT];
            reset_flags_aux[`RSB_FLG_IRQSEL] <= wdata[`RSB_FLG_IRQSEL];
            reset_flags_aux[`RSB_FLG_GEN]    <= wdata[`RSB_FLG_GEN];
            reset_flags_aux[`RSB_FLG_DPTR]   <= wdata[`RSB_FLG_DPTR];
         end
         if (fault_hit && fault_quiet) begin
            reset_flags_aux[`RSB_FLG_FAULT] <= 1'b1;
         end
         if (fault_hit && !fault_quiet
             && fault_control[`RSB_FC_IRQ_EN]) begin
            reset_flags_aux[`RSB_FLG_IRQSEL] <= 1'b1;
         end
      end
   end

   // ==========================================================
   // watchdog_control: prescaler survives all but power-on
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         watchdog_control <= `RSB_WD_POR;
      end else if (enter) begin
         watchdog_control[`RSB_WD_RUN]  <= 1'b0;
         watchdog_control[`RSB_WD_CLR]  <= 1'b0;
         watchdog_control[`RSB_WD_TOF]  <= 1'b0;
         watchdog_control[`RSB_WD_IDLE] <= 1'b0;
         if (next_kind == rsb_pkg::RSB_K_WDOG) begin
            watchdog_control[`RSB_WD_RSTF] <= 1'b1;
         end
      end else if (wr_wdog) begin
         // Clear bit is a strobe and never stored
         watchdog_control[`RSB_WD_RUN]  <= wdata[`RSB_WD_RUN];
         watchdog_control[`RSB_WD_TOF]  <= wdata[`RSB_WD_TOF];
         watchdog_control[`RSB_WD_IDLE] <= wdata[`RSB_WD_IDLE];
         watchdog_control[`RSB_WD_RSTF] <= wdata[`RSB_WD_RSTF];
         watchdog_control[`RSB_WD_PS_HI:`RSB_WD_PS_LO] <=
            wdata[`RSB_WD_PS_HI:`RSB_WD_PS_LO];
      end
   end

   // Restart pulse for the external watchdog counter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         watchdog_clear_o <= 1'b0;
      end else begin
         watchdog_clear_o <= wr_wdog && wdata[`RSB_WD_CLR];
      end
   end

   // ==========================================================
   // fault_control: interrupt instead of reset on bad fetch
   always_ff @(posedge clk_i) begin
      if (rst_i || enter) begin
         fault_control <= '0;
      end else if (wr_fault) begin
         fault_control[`RSB_FC_IRQ_EN] <= wdata[`RSB_FC_IRQ_EN];
      end
   end

   // ==========================================================
   // Read mux; unmapped addresses read zero
   always_comb begin
      next_rdata = '0;
      if (sel_chip) begin
         next_rdata = chip_control;
      end else if (sel_flags) begin
         next_rdata = reset_flags_aux;
      end else if (sel_wdog) begin
         next_rdata = watchdog_control;
      end else if (sel_fault) begin
         next_rdata = fault_control;
      end
   end

   // Ack one cycle after the request, data with it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= req;
         if (req && !wb_we_i) begin
            wb_dat_o <= {24'h000000, next_rdata};
         end
      end
   end

   // ==========================================================
   // System outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sys_rst_o      <= 1'b1;
         restart_addr_o <= `RSB_RESET_VECTOR;
      end else begin
         sys_rst_o      <= (state == rsb_pkg::RSB_HOLD) ? !leave : enter;
         restart_addr_o <= `RSB_RESET_VECTOR;
      end
   end

   // Boot area follows the live select bit at reset exit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         boot_loader_o <= 1'b0;
      end else if (leave) begin
         boot_loader_o <= chip_control[`RSB_CHIP_BOOT];
      end
   end

   // Stall the CPU from the requesting write until reset ends
   assign cpu_hold_o = soft_wr || chip_control[`RSB_CHIP_SWREQ]
                       || (state == rsb_pkg::RSB_HOLD);

   // Watchdog setup out to the external counter
   assign watchdog_run_o      = watchdog_control[`RSB_WD_RUN];
   assign watchdog_prescale_o =
      watchdog_control[`RSB_WD_PS_HI:`RSB_WD_PS_LO];

endmodule

//--- verification/rsb_top_sva.sv
// Port-level assertions for the reset sequencer
`timescale 1ns/1ps
`include "rsb_cfg.svh"
module rsb_top_sva (
   input wire logic                 clk_i,
   input wire logic                 rst_i,
   input wire logic                 wb_cyc_i,
   input wire logic                 wb_stb_i,
   input wire logic                 wb_we_i,
   input wire logic [`RSB_AW-1:0]   wb_adr_i,
   input wire logic [31:0]          wb_dat_i,
   input wire logic                 wb_ack_o,
   input wire logic                 reset_pin_n_i,
   input wire logic                 ta_open_i,
   input wire logic [`RSB_DW-1:0]   config_byte_zero_i,
   input wire logic                 ocd_active_i,
   input wire logic                 fetch_valid_i,
   input wire logic [15:0]          fetch_addr_i,
   input wire logic                 wdt_expired_i,
   input wire logic                 sys_rst_o,
   input wire logic                 cpu_hold_o,
   input wire logic [15:0]          restart_addr_o,
   input wire logic                 watchdog_clear_o,
   input wire logic [2:0]           watchdog_prescale_o
);
   // ==========================================================
   // Helper logic
   logic [4:0] lowcnt;
   logic       fen;
   logic       wr_req;
   logic       bad_fetch;
   logic       quiet;

   // Request and fetch decodes
   assign wr_req    = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   assign bad_fetch = fetch_valid_i && fetch_addr_i >= `RSB_FLASH_LIMIT;
   assign quiet     = ocd_active_i && !config_byte_zero_i[`RSB_CFG_DBG];

   // Pin low time, saturating
   always_ff @(posedge clk_i) begin
      if (rst_i || reset_pin_n_i) begin
         lowcnt <= 5'h00;
      end else if (lowcnt != 5'h1f) begin
         lowcnt <= lowcnt + 5'h01;
      end
   end

   // Fault irq enable shadow
   always_ff @(posedge clk_i) begin
      if (rst_i || sys_rst_o) begin
         fen <= 1'b0;
      end else if (wr_req && wb_adr_i == 10'h2c0) begin
         fen <= wb_dat_i[0];
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_ACK_NEXT:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
         |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing wrong");
   AST_PIN_LONG:
      assert property (lowcnt == 5'h1f |-> sys_rst_o)
         else $error("long pin low gave no reset");
   AST_PIN_SHORT:
      assert property (lowcnt != 5'h00 && lowcnt < 5'h17 && !sys_rst_o
         && !cpu_hold_o && !wdt_expired_i && !bad_fetch |=> !sys_rst_o)
         else $error("short pin low gave a reset");
   AST_FAULT_RST:
      assert property (bad_fetch && !fen && !quiet && !sys_rst_o
         |-> ##[1:3] sys_rst_o) else $error("bad fetch gave no reset");
   AST_FAULT_QUIET:
      assert property (bad_fetch && quiet && !sys_rst_o && !cpu_hold_o
         && !wdt_expired_i && reset_pin_n_i |=> !sys_rst_o [*3])
         else $error("debug fetch fault reset the system");
   AST_WDOG_RST:
      assert property (wdt_expired_i && !sys_rst_o |-> ##[1:3] sys_rst_o)
         else $error("watchdog expiry gave no reset");
   AST_HOLD_LEN:
      assert property ($rose(sys_rst_o) |=> sys_rst_o [*8])
         else $error("reset pulse too short");
   AST_WDOG_PS:
      assert property (wdt_expired_i && !sys_rst_o
         |=> $stable(watchdog_prescale_o) [*6])
         else $error("prescale changed by watchdog reset");
   AST_SOFT_HOLD:
      assert property (wr_req && ta_open_i && wb_adr_i == 10'h27c
         && wb_dat_i[7] && !sys_rst_o
         |-> cpu_hold_o throughout ##[1:4] sys_rst_o)
         else $error("soft reset request not held into reset");
   AST_WDOG_CLR:
      assert property (wr_req && ta_open_i && wb_adr_i == 10'h2a8
         && wb_dat_i[6] && !sys_rst_o
         |-> ##[1:2] watchdog_clear_o ##1 !watchdog_clear_o)
         else $error("watchdog clear pulse wrong");
   AST_VECTOR:
      assert property (sys_rst_o |-> restart_addr_o == `RSB_RESET_VECTOR)
         else $error("restart address not zero");
endmodule

//--- verification/tb_top.sv
// Directed bench for the reset sequencer
`timescale 1ns/1ps
module tb_top;
   // ==========================================================
   // Stimulus and observed signals
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [9:0]  wb_adr_i = 10'h000;
   logic [31:0] wb_dat_i = 32'h00000000;
   logic        reset_pin_n_i = 1'b1;
   logic        ta_open_i = 1'b0;
   logic [7:0]  config_byte_zero_i = 8'h10;
   logic        ocd_active_i = 1'b0;
   logic        fetch_valid_i = 1'b0;
   logic [15:0] fetch_addr_i = 16'h0000;
   logic        wdt_expired_i = 1'b0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        sys_rst_o;
   logic        cpu_hold_o;
   logic        boot_loader_o;
   logic [15:0] restart_addr_o;
   logic        watchdog_clear_o;
   logic        watchdog_run_o;
   logic [2:0]  watchdog_prescale_o;
   logic [31:0] rd_q;
   int          bad_count = 0;
   int          n_compared = 0;
   int          cycles = 0;
   localparam logic [9:0] a_chip = 10'h27c;
   localparam logic [9:0] a_flg  = 10'h288;
   localparam logic [9:0] a_wdg  = 10'h2a8;
   localparam logic [9:0] a_flt  = 10'h2c0;

   rsb_top dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .reset_pin_n_i, .ta_open_i, .config_byte_zero_i, .ocd_active_i,
      .fetch_valid_i, .fetch_addr_i, .wdt_expired_i, .sys_rst_o,
      .cpu_hold_o, .boot_loader_o, .restart_addr_o, .watchdog_clear_o,
      .watchdog_run_o, .watchdog_prescale_o);

   // 200 MHz clock
   always #2.5 clk_i = ~clk_i;

   // Hang guard
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         bad_count++;
         test_done();
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   // Classic single cycle; waits for ack
   task automatic wb(input logic we, input logic [9:0] a,
                     input logic [7:0] d, input logic ta);
      int n;
      @(posedge clk_i);
      wb_cyc_i  <= 1'b1;
      wb_stb_i  <= 1'b1;
      wb_we_i   <= we;
      wb_adr_i  <= a;
      wb_dat_i  <= {24'h000000, d};
      ta_open_i <= ta;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      chk(32'(wb_ack_o), 32'h1);
      rd_q = wb_dat_o;
      wb_cyc_i  <= 1'b0;
      wb_stb_i  <= 1'b0;
      wb_we_i   <= 1'b0;
      ta_open_i <= 1'b0;
   endtask

   task automatic rchk(input logic [9:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00, 1'b0);
      chk(rd_q, {24'h000000, e});
   endtask

   // Sees the reset begin, then waits for its end
   task automatic await_reset();
      int n;
      n = 0;
      while (sys_rst_o !== 1'b1 && n < 60) begin
         @(posedge clk_i);
         n++;
      end
      chk(32'(sys_rst_o), 32'h1);
      n = 0;
      while (sys_rst_o !== 1'b0 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      chk(32'(sys_rst_o), 32'h0);
      @(posedge clk_i);
   endtask

   task automatic no_rst();
      repeat (12) @(posedge clk_i);
      chk(32'(sys_rst_o), 32'h0);
   endtask

   task automatic pin_low(input int n);
      @(posedge clk_i);
      reset_pin_n_i <= 1'b0;
      repeat (n) @(posedge clk_i);
      reset_pin_n_i <= 1'b1;
   endtask

   task automatic fetch(input logic [15:0] a);
      @(posedge clk_i);
      fetch_valid_i <= 1'b1;
      fetch_addr_i  <= a;
      @(posedge clk_i);
      fetch_valid_i <= 1'b0;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_por_guard();
      rchk(a_chip, 8'h02);
      rchk(a_flg, 8'h00);
      rchk(a_wdg, 8'h07);
      rchk(10'h004, 8'h00);
      chk(32'(boot_loader_o), 32'h1);
      wb(1'b1, a_wdg, 8'h01, 1'b0);
      rchk(a_wdg, 8'h07);
      wb(1'b1, a_chip, 8'h80, 1'b0);
      no_rst();
      wb(1'b1, a_wdg, 8'h47, 1'b1);
      rchk(a_wdg, 8'h07);
      $display("test por and guard done");
   endtask

   task automatic t_pin_soft();
      pin_low(20);
      no_rst();
      config_byte_zero_i <= 8'h90;
      pin_low(36);
      await_reset();
      rchk(a_flg, 8'h40);
      rchk(a_chip, 8'h00);
      config_byte_zero_i <= 8'h10;
      wb(1'b1, a_chip, 8'h80, 1'b1);
      await_reset();
      rchk(a_flg, 8'hc0);
      rchk(a_chip, 8'h00);
      chk(32'(boot_loader_o), 32'h0);
      wb(1'b1, a_flg, 8'h40, 1'b0);
      rchk(a_flg, 8'h40);
      $display("test pin and soft done");
   endtask

   task automatic t_wdog();
      wb(1'b1, a_wdg, 8'h85, 1'b1);
      chk(32'(watchdog_run_o), 32'h1);
      wb(1'b1, a_flg, 8'h48, 1'b0);
      rchk(a_flg, 8'h48);
      @(posedge clk_i);
      wdt_expired_i <= 1'b1;
      @(posedge clk_i);
      wdt_expired_i <= 1'b0;
      await_reset();
      rchk(a_wdg, 8'h0d);
      rchk(a_flg, 8'h40);
      chk(32'(watchdog_prescale_o), 32'h5);
      chk(32'(watchdog_run_o), 32'h0);
      chk(32'(boot_loader_o), 32'h1);
      chk(32'(restart_addr_o), 32'h0);
      $display("test watchdog done");
   endtask

   task automatic t_fault();
      wb(1'b1, a_flt, 8'h01, 1'b0);
      fetch(16'h2000);
      no_rst();
      rchk(a_flg, 8'h50);
      wb(1'b1, a_flt, 8'h00, 1'b0);
      config_byte_zero_i <= 8'h80;
      ocd_active_i <= 1'b1;
      fetch(16'h2000);
      no_rst();
      rchk(a_flg, 8'h70);
      ocd_active_i <= 1'b0;
      fetch(16'h1fff);
      no_rst();
      fetch(16'hffff);
      await_reset();
      rchk(a_flg, 8'h60);
      rchk(a_wdg, 8'h0d);
      rchk(a_flt, 8'h00);
      chk(32'(boot_loader_o), 32'h0);
      wb(1'b1, a_flg, 8'h20, 1'b0);
      rchk(a_flg, 8'h20);
      $display("test fault done");
   endtask

   task automatic test_done();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      await_reset();
      t_por_guard();
      t_pin_soft();
      t_wdog();
      t_fault();
      test_done();
   end
endmodule

bind rsb_top rsb_top_sva chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .reset_pin_n_i, .ta_open_i,
   .config_byte_zero_i, .ocd_active_i, .fetch_valid_i, .fetch_addr_i,
   .wdt_expired_i, .sys_rst_o, .cpu_hold_o, .restart_addr_o,
   .watchdog_clear_o, .watchdog_prescale_o);
